// [dv/tb_exec_interrupt_status_word.sv]
`timescale 1ns/1ps
module tb_exec_interrupt_status_word;
  logic        hclk;
  logic        hresetn;
  logic        hce;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  wire logic   hready;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        branch_xchg_valid;
  logic        branch_target_bit0;
  logic        exc_entry_valid;
  logic [5:0]  exc_entry_number;
  logic        vector_bit0;
  logic        exc_return_valid;
  logic [31:0] stacked_status_word;
  logic [5:0]  return_exc_number;
  logic        multi_suspend_valid;
  logic [3:0]  multi_next_reg;
  logic        it_start_valid;
  logic [7:0]  it_start_state;
  logic        instr_retire;
  logic        instr_exec_valid;
  logic        isa_state;
  logic        cond_block_active;
  logic [7:0]  cond_block_state;
  logic        resume_valid;
  logic [3:0]  resume_reg;
  logic [5:0]  active_exception_number;
  logic        exec_fault;
  logic        lockup;
  int          error_cnt;
  int          total_checks;
  logic [31:0] rd;
  logic [7:0]  f;
  logic [5:0]  codes [11];

  assign hready = hreadyout;

  eisw_top dut (
    .hclk                    (hclk),
    .hresetn                 (hresetn),
    .hce                     (hce),
    .hsel                    (hsel),
    .haddr                   (haddr),
    .htrans                  (htrans),
    .hwrite                  (hwrite),
    .hsize                   (hsize),
    .hwdata                  (hwdata),
    .hready                  (hready),
    .hrdata                  (hrdata),
    .hreadyout               (hreadyout),
    .hresp                   (hresp),
    .branch_xchg_valid       (branch_xchg_valid),
    .branch_target_bit0      (branch_target_bit0),
    .exc_entry_valid         (exc_entry_valid),
    .exc_entry_number        (exc_entry_number),
    .vector_bit0             (vector_bit0),
    .exc_return_valid        (exc_return_valid),
    .stacked_status_word     (stacked_status_word),
    .return_exc_number       (return_exc_number),
    .multi_suspend_valid     (multi_suspend_valid),
    .multi_next_reg          (multi_next_reg),
    .it_start_valid          (it_start_valid),
    .it_start_state          (it_start_state),
    .instr_retire            (instr_retire),
    .instr_exec_valid        (instr_exec_valid),
    .isa_state               (isa_state),
    .cond_block_active       (cond_block_active),
    .cond_block_state        (cond_block_state),
    .resume_valid            (resume_valid),
    .resume_reg              (resume_reg),
    .active_exception_number (active_exception_number),
    .exec_fault              (exec_fault),
    .lockup                  (lockup)
  );

  always #2 hclk = ~hclk;

  // Expected full status word
  function automatic logic [31:0] word(input logic t, input logic [7:0] fl, input logic [5:0] e);
    word = {5'h00, fl[1:0], t, 8'h00, fl[7:2], 4'h0, e};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // Single word transfer
  task automatic bus(input logic [11:0] a, input logic wr, input logic [31:0] wd,
                     output logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {20'h0_0000, a};
    hwrite <= wr;
    hsize  <= 3'h2;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    d = hrdata;
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input string m);
    bus(a, 1'b0, 32'h0000_0000, rd);
    chk(rd, exp, m);
  endtask

  // Core event taken at next edge, outputs settled afterwards
  task automatic fire();
    @(posedge hclk);
    branch_xchg_valid   <= 1'b0;
    exc_entry_valid     <= 1'b0;
    exc_return_valid    <= 1'b0;
    multi_suspend_valid <= 1'b0;
    it_start_valid      <= 1'b0;
    instr_retire        <= 1'b0;
    instr_exec_valid    <= 1'b0;
    #1;
  endtask

  task automatic results();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (6000) @(posedge hclk);
    error_cnt++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    results();
  end

  initial begin
    {hclk, hresetn, hsel, haddr, htrans, hwrite, hsize, hwdata} = '0;
    {branch_xchg_valid, branch_target_bit0, exc_entry_valid, exc_entry_number} = '0;
    {vector_bit0, exc_return_valid, stacked_status_word, return_exc_number} = '0;
    {multi_suspend_valid, multi_next_reg, it_start_valid, it_start_state} = '0;
    {instr_retire, instr_exec_valid} = '0;
    hce = 1'b1;
    error_cnt = 0;
    total_checks = 0;
    codes = '{6'h00, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h0B, 6'h0E, 6'h0F, 6'h10, 6'h2D};
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    rd_chk(12'h000, word(1'b1, 8'h00, 6'h00), "reset word");
    exc_entry_valid <= 1'b1;
    fire();
    chk(32'(isa_state), 32'h0000_0000, "vector bit0 clear");
    exc_entry_valid <= 1'b1;
    vector_bit0 <= 1'b1;
    fire();
    chk(32'(isa_state), 32'h0000_0001, "vector bit0 set");
    branch_xchg_valid <= 1'b1;
    fire();
    rd_chk(12'h000, word(1'b0, 8'h00, 6'h00), "branch clears state");
    instr_exec_valid <= 1'b1;
    fire();
    chk(32'(exec_fault), 32'h0000_0001, "fault raised");
    @(posedge hclk);
    #1;
    chk({exec_fault, lockup}, 32'h0000_0000, "fault one cycle");
    branch_xchg_valid <= 1'b1;
    branch_target_bit0 <= 1'b1;
    fire();
    chk(32'(isa_state), 32'h0000_0001, "branch sets state");
    multi_suspend_valid <= 1'b1;
    multi_next_reg <= 4'h5;
    fire();
    chk(32'(cond_block_state), 32'h0000_0050, "suspend field");
    rd_chk(12'h000, word(1'b1, 8'h50, 6'h00), "suspend word");
    exc_entry_valid <= 1'b1;
    exc_entry_number <= 6'h13;
    fire();
    rd_chk(12'h000, word(1'b1, 8'h00, 6'h13), "entry word");
    rd_chk(12'h004, word(1'b1, 8'h00, 6'h00), "exec view");
    rd_chk(12'h008, 32'h0000_0013, "intr view");
    bus(12'h000, 1'b1, 32'hFFFF_FFFF, rd);
    rd_chk(12'h000, word(1'b1, 8'h00, 6'h13), "write ignored");
    rd_chk(12'h00C, 32'h0000_0000, "unmapped");
    exc_return_valid <= 1'b1;
    stacked_status_word <= word(1'b1, 8'h50, 6'h13);
    fire();
    chk({resume_valid, resume_reg, cond_block_state}, 32'h0000_1550, "resume");
    chk(32'(active_exception_number), 32'h0000_0000, "return number");
    @(posedge hclk);
    #1;
    chk(32'(resume_valid), 32'h0000_0000, "resume one cycle");
    foreach (codes[i]) begin
      exc_entry_valid <= 1'b1;
      exc_entry_number <= codes[i];
      fire();
      rd_chk(12'h008, 32'(codes[i]), "exception number");
    end
    exc_return_valid <= 1'b1;
    stacked_status_word <= word(1'b0, 8'h00, 6'h00);
    fire();
    chk(32'(isa_state), 32'h0000_0000, "return clears state");
    exc_return_valid <= 1'b1;
    stacked_status_word <= word(1'b1, 8'h00, 6'h00);
    fire();
    chk(32'(isa_state), 32'h0000_0001, "return sets state");
    f = 8'hE1;
    it_start_valid <= 1'b1;
    it_start_state <= f;
    fire();
    chk(32'(cond_block_active), 32'h0000_0001, "block active");
    rd_chk(12'h000, word(1'b1, f, 6'h00), "split field");
    repeat (4) begin
      instr_retire <= 1'b1;
      fire();
      f = (f[2:0] == 3'h0) ? 8'h00 : {f[7:5], f[3:0], 1'b0};
      chk(32'(cond_block_state), 32'(f), "block step");
    end
    chk(32'(cond_block_active), 32'h0000_0000, "block ended");
    hce <= 1'b0;
    branch_xchg_valid <= 1'b1;
    branch_target_bit0 <= 1'b0;
    fire();
    chk(32'(isa_state), 32'h0000_0001, "frozen");
    hce <= 1'b1;
    exc_entry_valid <= 1'b1;
    exc_entry_number <= 6'h02;
    vector_bit0 <= 1'b0;
    fire();
    instr_exec_valid <= 1'b1;
    fire();
    chk({exec_fault, lockup}, 32'h0000_0001, "lockup entered");
    repeat (3) @(posedge hclk);
    #1;
    chk(32'(lockup), 32'h0000_0001, "lockup sticky");
    results();
  end
endmodule

// [verilog/eisw_ahb_slave.sv]
`timescale 1ns/1ps
module eisw_ahb_slave (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hce,
  input  wire logic        hsel,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] read_word,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp
);
  eisw_pkg::eisw_ahb_st_t r;
  eisw_pkg::eisw_ahb_st_t next_r;
  logic                   rd_take;

  // Reads captured in the address phase; writes fall on the floor
  assign rd_take = hsel && hready && htrans[1] && !hwrite;

  always_comb begin
    next_r = r;
    if (rd_take) begin
      next_r.rdata = (hsize == `EISW_HSIZE_WORD) ? read_word : `EISW_RDATA_RST;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= `EISW_RDATA_RST;
    end else if (hce) begin
      r <= next_r;
    end
  end

  assign hrdata    = r.rdata;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
endmodule

// [verilog/eisw_cfg.svh]
`ifndef EISW_CFG_SVH
`define EISW_CFG_SVH
// Register offsets
`define EISW_OFF_PSW      12'h000
`define EISW_OFF_EXEC     12'h004
`define EISW_OFF_INTR     12'h008
// Field positions
`define EISW_ISA_BIT      24
`define EISW_ICIT_HI_MSB  26
`define EISW_ICIT_HI_LSB  25
`define EISW_ICIT_LO_MSB  15
`define EISW_ICIT_LO_LSB  10
`define EISW_EXC_MSB      5
// Reset values
`define EISW_EXEC_RST     11'h400
`define EISW_EXC_RST      6'h00
`define EISW_RDATA_RST    32'h0000_0000
// Exception numbers
`define EISW_EXC_THREAD   6'h00
`define EISW_EXC_NMI      6'h02
`define EISW_EXC_HARD     6'h03
`define EISW_EXC_USAGE    6'h06
`define EISW_EXC_IRQ_BASE 6'h10
// Bus encodings
`define EISW_HSIZE_WORD   3'h2
`endif

// [verilog/eisw_exec_state.sv]
`timescale 1ns/1ps
module eisw_exec_state (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hce,
  input  wire logic        exc_entry_valid,
  input  wire logic        vector_bit0,
  input  wire logic        exc_return_valid,
  input  wire logic [31:0] stacked_status_word,
  input  wire logic        multi_suspend_valid,
  input  wire logic [3:0]  multi_next_reg,
  input  wire logic        branch_xchg_valid,
  input  wire logic        branch_target_bit0,
  input  wire logic        it_start_valid,
  input  wire logic [7:0]  it_start_state,
  input  wire logic        instr_retire,
  output logic             isa_state,
  output logic             cond_block_active,
  output logic      [7:0]  icit_field,
  output logic             resume_valid,
  output logic      [3:0]  resume_reg
);
  eisw_pkg::eisw_exec_st_t r;
  eisw_pkg::eisw_exec_st_t next_r;
  logic [7:0]              stk_fld;
  logic [7:0]              adv;

  function automatic logic [7:0] it_step(input logic [7:0] s);
    it_step = (s[2:0] == 3'h0) ? 8'h00 : {s[7:5], s[3:0], 1'b0};
  endfunction

  assign stk_fld = {stacked_status_word[`EISW_ICIT_LO_MSB:`EISW_ICIT_LO_LSB],
                    stacked_status_word[`EISW_ICIT_HI_MSB:`EISW_ICIT_HI_LSB]};
  assign adv     = it_step(r.field);

  always_comb begin
    next_r        = r;
    next_r.resume = 1'b0;
    if (exc_entry_valid) begin
      next_r.isa = vector_bit0;
      next_r.field = 8'h00;
      next_r.is_it = 1'b0;
    end else if (exc_return_valid) begin
      next_r.isa    = stacked_status_word[`EISW_ISA_BIT];
      next_r.field  = stk_fld;
      next_r.is_it  = |stk_fld[3:0];
      next_r.resume = !(|stk_fld[3:0]) && (|stk_fld[7:4]);
    end else if (multi_suspend_valid) begin
      next_r.field = {multi_next_reg, 4'h0};
      next_r.is_it = 1'b0;
    end else if (branch_xchg_valid) begin
      next_r.isa = branch_target_bit0;
    end else if (it_start_valid) begin
      next_r.field = it_start_state;
      next_r.is_it = |it_start_state[3:0];
    end else if (instr_retire) begin
      next_r.field = r.is_it ? adv : 8'h00;
      next_r.is_it = r.is_it && (|adv[3:0]);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= `EISW_EXEC_RST;
    end else if (hce) begin
      r <= next_r;
    end
  end

  assign isa_state         = r.isa;
  assign cond_block_active = r.is_it;
  assign icit_field        = r.field;
  assign resume_valid      = r.resume;
  assign resume_reg        = r.field[7:4];

  AST_ISA_BRANCH: assert property (@(posedge hclk) disable iff (!hresetn)
    hce && branch_xchg_valid && !exc_entry_valid && !exc_return_valid && !multi_suspend_valid
    |=> isa_state == $past(branch_target_bit0))
    else $error("state bit not taken from branch target");
  AST_ISA_VECTOR: assert property (@(posedge hclk) disable iff (!hresetn)
    hce && exc_entry_valid |=> isa_state == $past(vector_bit0) && icit_field == 8'h00)
    else $error("state bit not taken from vector bit 0");
  AST_RESUME: assert property (@(posedge hclk) disable iff (!hresetn)
    resume_valid |-> !cond_block_active && resume_reg != 4'h0)
    else $error("resume flagged without continuable state");
  AST_CI_ZERO: assert property (@(posedge hclk) disable iff (!hresetn)
    !cond_block_active |-> icit_field[3:0] == 4'h0)
    else $error("continuable state has nonzero low bits");
endmodule

// [verilog/eisw_pkg.sv]
`include "eisw_cfg.svh"
package eisw_pkg;
  typedef enum logic [1:0] {
    EISW_V_PSW  = 2'b00,
    EISW_V_EXEC = 2'b01,
    EISW_V_INTR = 2'b10,
    EISW_V_NONE = 2'b11
  } eisw_view_t;

  typedef enum logic {
    EISW_ST_RUN    = 1'b0,
    EISW_ST_LOCKUP = 1'b1
  } eisw_mode_t;

  typedef struct packed {
    logic       isa;
    logic       is_it;
    logic [7:0] field;
    logic       resume;
  } eisw_exec_st_t;

  typedef struct packed {
    eisw_mode_t mode;
    logic       fault;
    logic [5:0] excnum;
  } eisw_top_st_t;

  typedef struct packed {
    logic [31:0] rdata;
  } eisw_ahb_st_t;

  function automatic eisw_view_t eisw_view_of(input logic [11:0] addr);
    case (addr)
      `EISW_OFF_PSW:  eisw_view_of = EISW_V_PSW;
      `EISW_OFF_EXEC: eisw_view_of = EISW_V_EXEC;
      `EISW_OFF_INTR: eisw_view_of = EISW_V_INTR;
      default:        eisw_view_of = EISW_V_NONE;
    endcase
  endfunction
endpackage

// [verilog/eisw_top.sv]
`timescale 1ns/1ps
// Notes on behaviour
// - Exchange branches and pop into the program counter load the state bit from target bit 0.
// - Exception return reloads the state bit from the stacked status word.
// - Exception entry loads the state bit from bit 0 of the vector word; reset sets it to 1.
// - Executing while the state bit is clear raises a fault or enters lockup.
// - An interrupted multi-register transfer stores its next register number in bits 15:12.
// - After servicing, the transfer resumes at the register held in bits 15:12.
// - While the split field holds continuable state, bits 11:10 read as zero.
// - The split field lives in bits 15:10 and 26:25, is read-only and resets to zero.
// - Conditional-block state steps through up to four conditional instructions.
// - Bits 23:16 and 9:6 are reserved, read-only and read as zero.
// - Bits 5:0 read the number of the exception being serviced.
// - A field reads meaningful content only through a view that includes it.
// - While the split field holds continuable state, bits 26:25 read as zero.
module eisw_top (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hce,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        branch_xchg_valid,
  input  wire logic        branch_target_bit0,
  input  wire logic        exc_entry_valid,
  input  wire logic [5:0]  exc_entry_number,
  input  wire logic        vector_bit0,
  input  wire logic        exc_return_valid,
  input  wire logic [31:0] stacked_status_word,
  input  wire logic [5:0]  return_exc_number,
  input  wire logic        multi_suspend_valid,
  input  wire logic [3:0]  multi_next_reg,
  input  wire logic        it_start_valid,
  input  wire logic [7:0]  it_start_state,
  input  wire logic        instr_retire,
  input  wire logic        instr_exec_valid,
  output logic             isa_state,
  output logic             cond_block_active,
  output logic      [7:0]  cond_block_state,
  output logic             resume_valid,
  output logic      [3:0]  resume_reg,
  output logic      [5:0]  active_exception_number,
  output logic             exec_fault,
  output logic             lockup
);
  eisw_pkg::eisw_top_st_t r;
  eisw_pkg::eisw_top_st_t next_r;
  eisw_pkg::eisw_view_t   view;
  logic [7:0]             icit;
  logic [31:0]            psw;
  logic [31:0]            read_word;
  logic                   bad_exec;
  logic                   in_fault_handler;
  logic                   rd_take;
  logic                   wr_take;

  eisw_exec_state u_exec (
    .hclk                (hclk),
    .hresetn             (hresetn),
    .hce                 (hce),
    .exc_entry_valid     (exc_entry_valid),
    .vector_bit0         (vector_bit0),
    .exc_return_valid    (exc_return_valid),
    .stacked_status_word (stacked_status_word),
    .multi_suspend_valid (multi_suspend_valid),
    .multi_next_reg      (multi_next_reg),
    .branch_xchg_valid   (branch_xchg_valid),
    .branch_target_bit0  (branch_target_bit0),
    .it_start_valid      (it_start_valid),
    .it_start_state      (it_start_state),
    .instr_retire        (instr_retire),
    .isa_state           (isa_state),
    .cond_block_active   (cond_block_active),
    .icit_field          (icit),
    .resume_valid        (resume_valid),
    .resume_reg          (resume_reg)
  );

  eisw_ahb_slave u_ahb (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hce       (hce),
    .hsel      (hsel),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hready    (hready),
    .read_word (read_word),
    .hrdata    (hrdata),
    .hreadyout (hreadyout),
    .hresp     (hresp)
  );

  // Full status word; reserved bits tied low
  always_comb begin
    psw = 32'h0000_0000;
    psw[`EISW_ICIT_HI_MSB:`EISW_ICIT_HI_LSB] = icit[1:0];
    psw[`EISW_ISA_BIT] = isa_state;
    psw[`EISW_ICIT_LO_MSB:`EISW_ICIT_LO_LSB] = icit[7:2];
    psw[`EISW_EXC_MSB:0] = r.excnum;
  end

  assign view = eisw_pkg::eisw_view_of(haddr[11:0]);

  // Each view shows only its own subset
  always_comb begin
    case (view)
      eisw_pkg::EISW_V_PSW: begin
        read_word = psw;
      end
      eisw_pkg::EISW_V_EXEC: begin
        read_word = {psw[31:6], 6'h00};
      end
      eisw_pkg::EISW_V_INTR: begin
        read_word = {26'h000_0000, psw[5:0]};
      end
      default: begin
        read_word = 32'h0000_0000;
      end
    endcase
  end

  assign in_fault_handler = (r.excnum == `EISW_EXC_HARD) || (r.excnum == `EISW_EXC_NMI);
  assign bad_exec         = instr_exec_valid && !isa_state;
  assign rd_take          = hsel && hready && htrans[1] && !hwrite;
  assign wr_take          = hsel && hready && htrans[1] && hwrite;

  // Exception number and execution-state fault tracking
  always_comb begin
    next_r       = r;
    next_r.fault = 1'b0;
    if (exc_entry_valid) begin
      next_r.excnum = exc_entry_number;
    end else if (exc_return_valid) begin
      next_r.excnum = return_exc_number;
    end
    case (r.mode)
      eisw_pkg::EISW_ST_RUN: begin
        if (bad_exec) begin
          if (in_fault_handler) begin
            next_r.mode = eisw_pkg::EISW_ST_LOCKUP;
          end else begin
            next_r.fault = 1'b1;
          end
        end
      end
      eisw_pkg::EISW_ST_LOCKUP: begin
        next_r.mode = eisw_pkg::EISW_ST_LOCKUP;
      end
      default: begin
        next_r.mode = eisw_pkg::EISW_ST_RUN;
      end
    endcase
  end

  // Bus writes never reach this state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= {eisw_pkg::EISW_ST_RUN, 1'b0, `EISW_EXC_RST};
    end else if (hce) begin
      r <= next_r;
    end
  end

  assign cond_block_state        = icit;
  assign active_exception_number = r.excnum;
  assign exec_fault              = r.fault;
  assign lockup                  = (r.mode == eisw_pkg::EISW_ST_LOCKUP);

  sequence s_bad_exec_plain;
    hce && bad_exec && !in_fault_handler && !lockup;
  endsequence

  sequence s_bad_exec_handler;
    hce && bad_exec && in_fault_handler && !lockup;
  endsequence

  sequence s_read_addr(eisw_pkg::eisw_view_t v);
    hce && rd_take && hsize == `EISW_HSIZE_WORD && view == v;
  endsequence

  AST_FAULT: assert property (@(posedge hclk) disable iff (!hresetn)
    s_bad_exec_plain |=> exec_fault && !lockup ##1 !exec_fault)
    else $error("fault not raised for clear state bit");

  AST_LOCKUP: assert property (@(posedge hclk) disable iff (!hresetn)
    s_bad_exec_handler |=> lockup [*4])
    else $error("lockup not entered or not held");

  AST_RESERVED: assert property (@(posedge hclk) disable iff (!hresetn)
    s_read_addr(eisw_pkg::EISW_V_PSW) |=> hrdata[23:16] == 8'h00 && hrdata[9:6] == 4'h0)
    else $error("reserved bits read nonzero");

  AST_EXCNUM: assert property (@(posedge hclk) disable iff (!hresetn)
    hce && exc_entry_valid |=> active_exception_number == $past(exc_entry_number))
    else $error("exception number not captured on entry");

  AST_EXC_READ: assert property (@(posedge hclk) disable iff (!hresetn)
    s_read_addr(eisw_pkg::EISW_V_INTR) |=> hrdata == {26'h000_0000, $past(r.excnum)})
    else $error("interrupt view does not show exception number");

  AST_EXEC_VIEW: assert property (@(posedge hclk) disable iff (!hresetn)
    s_read_addr(eisw_pkg::EISW_V_EXEC) |=> hrdata[5:0] == 6'h00
      && hrdata[`EISW_ISA_BIT] == $past(isa_state))
    else $error("execution view leaks exception number");

  AST_SUSPEND: assert property (@(posedge hclk) disable iff (!hresetn)
    hce && multi_suspend_valid && !exc_entry_valid && !exc_return_valid
    |=> psw[15:12] == $past(multi_next_reg) && psw[11:10] == 2'h0 && psw[26:25] == 2'h0)
    else $error("next register not stored in split field");

  AST_RETURN: assert property (@(posedge hclk) disable iff (!hresetn)
    hce && exc_return_valid && !exc_entry_valid
    |=> psw[31:10] == {5'h00, $past(stacked_status_word[26:24]), 8'h00,
                       $past(stacked_status_word[15:10])})
    else $error("state not restored from stacked word");

  AST_WRITE_IGNORED: assert property (@(posedge hclk) disable iff (!hresetn)
    hce && wr_take && !exc_entry_valid && !exc_return_valid && !multi_suspend_valid
      && !branch_xchg_valid && !it_start_valid && !instr_retire
    |=> $stable(psw))
    else $error("bus write altered status word");

  AST_IT_STEP: assert property (@(posedge hclk) disable iff (!hresetn)
    hce && instr_retire && cond_block_active && !exc_entry_valid && !exc_return_valid
      && !multi_suspend_valid && !branch_xchg_valid && !it_start_valid
      && icit[2:0] != 3'h0
    |=> icit == {$past(icit[7:5]), $past(icit[3:0]), 1'b0})
    else $error("conditional block did not advance");

  AST_IT_END: assert property (@(posedge hclk) disable iff (!hresetn)
    hce && instr_retire && cond_block_active && !exc_entry_valid && !exc_return_valid
      && !multi_suspend_valid && !branch_xchg_valid && !it_start_valid && icit[2:0] == 3'h0
    |=> icit == 8'h00 && !cond_block_active)
    else $error("conditional block did not end");

  AST_RETIRE_CI: assert property (@(posedge hclk) disable iff (!hresetn)
    hce && instr_retire && !cond_block_active && !exc_entry_valid && !exc_return_valid
      && !multi_suspend_valid && !branch_xchg_valid && !it_start_valid
    |=> icit == 8'h00)
    else $error("continuable state kept after retire");

  AST_LOCK_STICKY: assert property (@(posedge hclk) disable iff (!hresetn)
    lockup |=> lockup)
    else $error("lockup released before reset");

  AST_NO_FAULT: assert property (@(posedge hclk) disable iff (!hresetn)
    hce && instr_exec_valid && isa_state |=> !exec_fault)
    else $error("fault raised with state bit set");

  AST_RET_NUM: assert property (@(posedge hclk) disable iff (!hresetn)
    hce && exc_return_valid && !exc_entry_valid |=> active_exception_number == $past(return_exc_number))
    else $error("exception number not restored on return");

  AST_FREEZE: assert property (@(posedge hclk) disable iff (!hresetn)
    !hce |=> $stable(psw) && $stable(lockup))
    else $error("state moved while clock enable low");

  AST_BRANCH_FIELD: assert property (@(posedge hclk) disable iff (!hresetn)
    hce && branch_xchg_valid && !exc_entry_valid && !exc_return_valid && !multi_suspend_valid
    |=> icit == $past(icit))
    else $error("branch altered split field");

  AST_VIEW_NONE: assert property (@(posedge hclk) disable iff (!hresetn)
    s_read_addr(eisw_pkg::EISW_V_NONE) |=> hrdata == 32'h0000_0000)
    else $error("unmapped read not zero");

  AST_READY: assert property (@(posedge hclk) disable iff (!hresetn)
    hreadyout && !hresp)
    else $error("bus answer not ready and okay");

  AST_PSW_READ: assert property (@(posedge hclk) disable iff (!hresetn)
    s_read_addr(eisw_pkg::EISW_V_PSW) |=> hrdata[`EISW_ISA_BIT] == $past(isa_state)
      && hrdata[5:0] == $past(r.excnum))
    else $error("full view does not show all fields");

  AST_RESUME_PULSE: assert property (@(posedge hclk) disable iff (!hresetn)
    hce && resume_valid && !exc_return_valid |=> !resume_valid)
    else $error("resume flag held too long");

  AST_SUSPEND_CI: assert property (@(posedge hclk) disable iff (!hresetn)
    hce && multi_suspend_valid && !exc_entry_valid && !exc_return_valid
    |=> !cond_block_active && !resume_valid)
    else $error("suspend left conditional state");

  AST_ENTRY_FIELD: assert property (@(posedge hclk) disable iff (!hresetn)
    hce && exc_entry_valid |=> !cond_block_active && !resume_valid)
    else $error("entry left split field active");

  AST_CI_HI: assert property (@(posedge hclk) disable iff (!hresetn)
    !cond_block_active |-> psw[26:25] == 2'h0)
    else $error("continuable state has nonzero high bits");
endmodule
